// ==== rtl/ctsf_pkg.sv ====
// Shared constants for the CAN time stamp timer and filter control block
`default_nettype none

package ctsf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets, decoded from haddr[7:0]
	localparam logic [7:0] CTSF_OFF_CONTROL = 8'h00;
	localparam logic [7:0] CTSF_OFF_TIMER   = 8'h04;
	localparam logic [7:0] CTSF_OFF_FCON5   = 8'h08;
	localparam logic [7:0] CTSF_OFF_FCON6   = 8'h0C;

	// Internal register indices
	localparam logic [1:0] CTSF_IDX_CONTROL = 2'h0;
	localparam logic [1:0] CTSF_IDX_TIMER   = 2'h1;
	localparam logic [1:0] CTSF_IDX_FCON5   = 2'h2;
	localparam logic [1:0] CTSF_IDX_FCON6   = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned CTSF_CAP_EN_BIT = 20;
	localparam int unsigned CTSF_STAMP_LSB  = 16;
	localparam int unsigned CTSF_PRE_LSB    = 0;
	localparam int unsigned CTSF_FLT_EN_BIT = 7;
	localparam int unsigned CTSF_MSEL_LSB   = 5;
	localparam int unsigned CTSF_FSEL_LSB   = 0;
	localparam int unsigned CTSF_NUM_SLOTS  = 6;

	// Slot order: filters 20, 21, 24, 25, 26, 27
	localparam logic [1:0] CTSF_SLOT_REG [CTSF_NUM_SLOTS] = '{
		CTSF_IDX_FCON5, CTSF_IDX_FCON5,
		CTSF_IDX_FCON6, CTSF_IDX_FCON6, CTSF_IDX_FCON6, CTSF_IDX_FCON6
	};
	localparam logic [1:0] CTSF_SLOT_LANE [CTSF_NUM_SLOTS] = '{
		2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h3
	};

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] CTSF_STAMP_RST = 16'h0000;
	localparam logic [15:0] CTSF_PRE_RST   = 16'h0000;
	localparam logic [7:0]  CTSF_FLT_RST   = 8'h00;
	localparam logic [31:0] CTSF_WORD_ZERO = 32'h0000_0000;

	// Shortest prescaler period in system clocks
	localparam logic [15:0] CTSF_PRE_MIN_PERIOD = 16'h0001;

	////////////////////////////////////////////////////////////////////////////
	// Offset decode: {hit, index}
	function automatic logic [2:0] ctsf_decode(input logic [7:0] off);
		logic [2:0] r;
		r = 3'h0;
		unique case (off)
			CTSF_OFF_CONTROL: r = {1'b1, CTSF_IDX_CONTROL};
			CTSF_OFF_TIMER:   r = {1'b1, CTSF_IDX_TIMER};
			CTSF_OFF_FCON5:   r = {1'b1, CTSF_IDX_FCON5};
			CTSF_OFF_FCON6:   r = {1'b1, CTSF_IDX_FCON6};
			default:          r = 3'h0;
		endcase
		return r;
	endfunction : ctsf_decode

endpackage : ctsf_pkg

`default_nettype wire

// ==== rtl/ctsf_filter_slot.sv ====
// One filter control byte with write lock and gated match
`default_nettype none

module ctsf_filter_slot
	import ctsf_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Register write
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_byte,
	// Acceptance result from the matcher
	input  wire logic       hit,
	// Control byte and routed match
	output logic      [7:0] ctrl,
	output logic      [7:0] ctrl_next,
	output logic            match
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] ctrl;
		logic       match;
	} ctsf_slot_state_t;

	ctsf_slot_state_t s_reg;
	ctsf_slot_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (wr_en) begin
			// Enable stays writable so a locked filter can still be switched off
			s_next.ctrl[CTSF_FLT_EN_BIT] = wr_byte[CTSF_FLT_EN_BIT];
			if (!s_reg.ctrl[CTSF_FLT_EN_BIT]) begin
				s_next.ctrl[CTSF_FLT_EN_BIT-1:0] = wr_byte[CTSF_FLT_EN_BIT-1:0];
			end
		end
		s_next.match = hit && s_reg.ctrl[CTSF_FLT_EN_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg.ctrl  <= CTSF_FLT_RST;
			s_reg.match <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ctrl      = s_reg.ctrl;
	assign ctrl_next = s_next.ctrl;
	assign match     = s_reg.match;

endmodule : ctsf_filter_slot

`default_nettype wire

// ==== rtl/ctsf_top.sv ====
// CAN time stamp timer and filter control registers behind an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`default_nettype none

// What this block does
// - Free-running 16-bit stamp counter while capture enabled
// - Prescale zero every clock, max every 65535
// - Counter and prescaler hold while capture disabled
// - Timer write clears prescaler count, loads setting from lower half
// - Stamp upper half, prescale lower half, reset zero
// - Per-filter enable bit, one enables
// - Two-bit selector picks one of four masks
// - Five-bit selector picks one of 32 FIFOs
// - Selector fields writable only while filter disabled
// - Filters 21 and 20 fields in fifth register
// - Filters 24 to 27 bytewise in sixth register
module ctsf_top
	import ctsf_pkg::*;
#(
	parameter int unsigned NUM_SLOTS = CTSF_NUM_SLOTS
)
(
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic      [31:0]            hrdata,
	// Time stamp
	output logic                        stamp_capture_enable,
	output logic      [15:0]            stamp_count,
	output logic      [15:0]            stamp_prescale,
	output logic                        stamp_tick,
	// Filters, slot order 20, 21, 24, 25, 26, 27
	input  wire logic [NUM_SLOTS-1:0]   filter_hit,
	output logic      [NUM_SLOTS-1:0]   filter_match,
	output logic      [NUM_SLOTS-1:0]   filter_enable_n,
	output logic      [2*NUM_SLOTS-1:0] filter_mask_select,
	output logic      [5*NUM_SLOTS-1:0] filter_fifo_select
);

	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic        cap_en;
		logic [15:0] stamp;
		logic [15:0] pre;
		logic [15:0] pre_cnt;
		logic        tick;
		logic        dp_write;
		logic [1:0]  dp_index;
		logic [31:0] rdata;
		logic        readyout;
		logic        resp;
	} ctsf_top_state_t;

	ctsf_top_state_t              s_reg;
	ctsf_top_state_t              s_next;

	logic [NUM_SLOTS-1:0]         slot_wr;
	logic [7:0]                   slot_byte [NUM_SLOTS];
	logic [7:0]                   slot_ctrl [NUM_SLOTS];
	logic [7:0]                   slot_ctrl_next [NUM_SLOTS];
	logic [2:0]                   dec;
	logic                         addr_take;
	logic [15:0]                  period_last;
	logic [31:0]                  fcon5_next;
	logic [31:0]                  fcon6_next;

	////////////////////////////////////////////////////////////////////////////
	// Address decode; hsel covers the upper address bits
	assign dec       = ctsf_decode(haddr[7:0]);
	assign addr_take = hsel && htrans[1] && hready;

	// Last prescaler count before an advance; setting 0 and 1 both give one clock
	assign period_last = ((s_reg.pre > CTSF_PRE_MIN_PERIOD) ? s_reg.pre : CTSF_PRE_MIN_PERIOD)
		- CTSF_PRE_MIN_PERIOD;

	////////////////////////////////////////////////////////////////////////////
	// Filter write strobes from the data phase
	always_comb begin
		for (int i = 0; i < NUM_SLOTS; i++) begin
			slot_wr[i]   = s_reg.dp_write && (s_reg.dp_index == CTSF_SLOT_REG[i]);
			slot_byte[i] = hwdata[8*CTSF_SLOT_LANE[i] +: 8];
		end
	end

	generate
		for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
			ctsf_filter_slot u_slot (
				.hclk      (hclk),
				.hresetn   (hresetn),
				.wr_en     (slot_wr[g]),
				.wr_byte   (slot_byte[g]),
				.hit       (filter_hit[g]),
				.ctrl      (slot_ctrl[g]),
				.ctrl_next (slot_ctrl_next[g]),
				.match     (filter_match[g])
			);
		end
	endgenerate

	// Read images of the filter registers, reserved lanes of the fifth read zero
	always_comb begin
		fcon5_next = CTSF_WORD_ZERO;
		fcon6_next = CTSF_WORD_ZERO;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (CTSF_SLOT_REG[i] == CTSF_IDX_FCON5) begin
				fcon5_next[8*CTSF_SLOT_LANE[i] +: 8] = slot_ctrl_next[i];
			end else begin
				fcon6_next[8*CTSF_SLOT_LANE[i] +: 8] = slot_ctrl_next[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_next      = s_reg;
		s_next.tick = 1'b0;

		// Stamp counter and prescaler; both freeze while capture is off
		if (s_reg.cap_en) begin
			if (s_reg.pre_cnt >= period_last) begin
				s_next.pre_cnt = CTSF_PRE_RST;
				s_next.stamp   = s_reg.stamp + 16'h0001;
				s_next.tick    = 1'b1;
			end else begin
				s_next.pre_cnt = s_reg.pre_cnt + 16'h0001;
			end
		end

		// Data phase writes; a timer write overrides a same-cycle advance
		if (s_reg.dp_write) begin
			unique case (s_reg.dp_index)
				CTSF_IDX_CONTROL: begin
					s_next.cap_en = hwdata[CTSF_CAP_EN_BIT];
				end
				CTSF_IDX_TIMER: begin
					s_next.stamp   = hwdata[CTSF_STAMP_LSB +: 16];
					s_next.pre     = hwdata[CTSF_PRE_LSB +: 16];
					s_next.pre_cnt = CTSF_PRE_RST;
					s_next.tick    = 1'b0;
				end
				CTSF_IDX_FCON5: begin
				end
				CTSF_IDX_FCON6: begin
				end
			endcase
		end

		// Address phase; unmapped offsets write nothing and read zero
		s_next.dp_write = addr_take && hwrite && dec[2];
		s_next.dp_index = dec[1:0];
		s_next.rdata    = CTSF_WORD_ZERO;
		if (addr_take && !hwrite && dec[2]) begin
			// Read the value as it stands after any write now finishing
			unique case (dec[1:0])
				CTSF_IDX_CONTROL: begin
					s_next.rdata[CTSF_CAP_EN_BIT] = s_next.cap_en;
				end
				CTSF_IDX_TIMER: begin
					s_next.rdata = {s_next.stamp, s_next.pre};
				end
				CTSF_IDX_FCON5: begin
					s_next.rdata = fcon5_next;
				end
				CTSF_IDX_FCON6: begin
					s_next.rdata = fcon6_next;
				end
			endcase
		end

		// Zero wait states, always OKAY
		s_next.readyout = 1'b1;
		s_next.resp     = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg.cap_en   <= 1'b0;
			s_reg.stamp    <= CTSF_STAMP_RST;
			s_reg.pre      <= CTSF_PRE_RST;
			s_reg.pre_cnt  <= CTSF_PRE_RST;
			s_reg.tick     <= 1'b0;
			s_reg.dp_write <= 1'b0;
			s_reg.dp_index <= CTSF_IDX_CONTROL;
			s_reg.rdata    <= CTSF_WORD_ZERO;
			s_reg.readyout <= 1'b1;
			s_reg.resp     <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hreadyout            = s_reg.readyout;
	assign hresp                = s_reg.resp;
	assign hrdata               = s_reg.rdata;
	assign stamp_capture_enable = s_reg.cap_en;
	assign stamp_count          = s_reg.stamp;
	assign stamp_prescale       = s_reg.pre;
	assign stamp_tick           = s_reg.tick;

	// Selector outputs straight from the slot flops
	always_comb begin
		for (int i = 0; i < NUM_SLOTS; i++) begin
			filter_enable_n[i]           = slot_ctrl[i][CTSF_FLT_EN_BIT];
			filter_mask_select[2*i +: 2] = slot_ctrl[i][CTSF_MSEL_LSB +: 2];
			filter_fifo_select[5*i +: 5] = slot_ctrl[i][CTSF_FSEL_LSB +: 5];
		end
	end

	// hsize is not checked: only whole-word transfers are supported
	logic unused_ok;
	assign unused_ok = ^{hsize, haddr[31:8]};

endmodule : ctsf_top

`default_nettype wire

// ==== test/ctsf_top_assertions.sv ====
// Concurrent checks on the stamp timer and filter block
`default_nettype none
module ctsf_chk
	import ctsf_pkg::*;
#(parameter int unsigned NUM_SLOTS = 6)
(
	// Clock, reset and bus
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic                   hready,
	input wire logic [31:0]            hrdata,
	// Stamp and filters
	input wire logic                   stamp_capture_enable,
	input wire logic [15:0]            stamp_count,
	input wire logic [15:0]            stamp_prescale,
	input wire logic                   stamp_tick,
	input wire logic [NUM_SLOTS-1:0]   filter_hit,
	input wire logic [NUM_SLOTS-1:0]   filter_match,
	input wire logic [NUM_SLOTS-1:0]   filter_enable_n,
	input wire logic [2*NUM_SLOTS-1:0] filter_mask_select,
	input wire logic [5*NUM_SLOTS-1:0] filter_fifo_select
);
	logic tk;
	logic wt_reg;
	logic rt_reg;
	assign tk = hsel && htrans[1] && hready && haddr[7:0] == CTSF_OFF_TIMER;
	// Timer access in its data phase; a write there beats any advance
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wt_reg <= 1'b0;
			rt_reg <= 1'b0;
		end else begin
			wt_reg <= tk && hwrite;
			rt_reg <= tk && !hwrite;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	property p_hold; !stamp_capture_enable && !wt_reg |=> $stable(stamp_count); endproperty
	a_hold: assert property (p_hold) else $error("stamp moved while paused");
	property p_step; $changed(stamp_count) && !$past(wt_reg) |-> stamp_count == 16'($past(stamp_count) + 16'h1);
	endproperty
	a_step: assert property (p_step) else $error("stamp step not plus one");
	property p_tick; $changed(stamp_count) && !$past(wt_reg) |-> stamp_tick; endproperty
	a_tick: assert property (p_tick) else $error("advance without tick");
	property p_fast; stamp_capture_enable && stamp_prescale < 16'h2 && !wt_reg |=> stamp_tick; endproperty
	a_fast: assert property (p_fast) else $error("small prescale missed a clock");
	property p_pre; !wt_reg |=> $stable(stamp_prescale); endproperty
	a_pre: assert property (p_pre) else $error("prescale changed without write");
	// Read data is the timer as it stands after the edge that took the address phase
	property p_ts; rt_reg |-> hrdata[31:16] == stamp_count && hrdata[15:0] == stamp_prescale; endproperty
	a_ts: assert property (p_ts) else $error("timer read layout wrong");
	property p_match; filter_match == ($past(filter_hit) & $past(filter_enable_n)); endproperty
	a_match: assert property (p_match) else $error("match not gated by enable");
	property p_lock(int i); filter_enable_n[i] |=> $stable(filter_mask_select[2*i+:2]) &&
		$stable(filter_fifo_select[5*i+:5]); endproperty
	for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_lk
		a_lock: assert property (p_lock(i)) else $error("locked field changed");
	end
	c_wrap: cover property (stamp_tick && stamp_count == 16'h0000);
	c_match: cover property (|filter_match);
	c_lock: cover property (&filter_enable_n[5:2]);
endmodule : ctsf_chk
bind ctsf_top ctsf_chk #(.NUM_SLOTS(NUM_SLOTS)) chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .stamp_capture_enable, .stamp_count, .stamp_prescale, .stamp_tick, .filter_hit, .filter_match,
	.filter_enable_n, .filter_mask_select, .filter_fifo_select);
`default_nettype wire

// ==== test/ctsf_top_bench.sv ====
// Self-checking bench for the stamp timer and filter block
`default_nettype none
module ctsf_top_bench
	import ctsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cap, tick;
	logic        rph = 1'b0;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, lf, d;
	logic [15:0] cnt, pre;
	logic [5:0]  hit, match, en;
	logic [11:0] msel;
	logic [29:0] fsel;
	logic [31:0] expq[$];
	int          miscompares, comparisons, n, q;
	int          ps[4] = '{0, 1, 2, 5};
	assign hready = hreadyout;
	ctsf_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout,
		.hresp, .hrdata, .stamp_capture_enable(cap), .stamp_count(cnt), .stamp_prescale(pre), .stamp_tick(tick),
		.filter_hit(hit), .filter_match(match), .filter_enable_n(en), .filter_mask_select(msel),
		.filter_fifo_select(fsel));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// Single word transfer; read expectations are queued for the monitor
	task bus(input logic [7:0] a, input logic w, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		if (!w) expq.push_back(v);
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : bus
	task gap(output int k);
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (tick !== 1'b1 && k < 100);
	endtask : gap
	task test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	always @(posedge hclk) begin
		if (rph) chk("hrdata", expq.pop_front(), hrdata);
		if (rph) chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
		rph <= hsel && htrans[1] && hready && !hwrite;
	end
	initial begin
		repeat (3000) @(posedge hclk);
		miscompares++;
		test_done();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		hit = 6'h00;
		lf = 32'h0001_6D27;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(8'h10, 1'b1, lf);
		for (int a = 0; a < 5; a++) bus(8'(4 * a), 1'b0, 32'h0000_0000);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			lf = lfsr(lf);
			d = k == 0 ? 32'h0000_0000 : k == 3 ? 32'h1F1F_1F1F : lf & 32'h1F1F_1F1F;
			d = d | (32'(k) * 32'h2020_2020);
			bus(CTSF_OFF_FCON6, 1'b1, d);
			bus(CTSF_OFF_FCON6, 1'b0, d);
			bus(CTSF_OFF_FCON5, 1'b1, d | 32'hFFFF_0000);
			bus(CTSF_OFF_FCON5, 1'b0, d & 32'h0000_FFFF);
			chk("msel", 32'({6{2'(k)}}), 32'(msel));
			chk("fsel", {2'h0, d[28:24], d[20:16], d[12:8], d[4:0], d[12:8], d[4:0]}, {2'h0, fsel});
		end
		$display("test fields done");
		// Fields are written with the enables only while disabled
		bus(CTSF_OFF_FCON6, 1'b1, 32'hE0E0_E0E0);
		bus(CTSF_OFF_FCON6, 1'b1, 32'h9F9F_9F9F);
		bus(CTSF_OFF_FCON6, 1'b0, 32'hE0E0_E0E0);
		bus(CTSF_OFF_FCON6, 1'b1, 32'h0000_0000);
		bus(CTSF_OFF_FCON6, 1'b0, 32'h6060_6060);
		bus(CTSF_OFF_FCON5, 1'b1, 32'h0000_8000);
		hit <= 6'h3F;
		repeat (2) @(posedge hclk);
		chk("match", 32'h0000_0002, {26'h0, match});
		chk("enable", 32'h0000_0002, {26'h0, en});
		hit <= 6'h00;
		$display("test filters done");
		bus(CTSF_OFF_TIMER, 1'b1, 32'h1234_0001);
		repeat (20) @(posedge hclk);
		bus(CTSF_OFF_TIMER, 1'b0, 32'h1234_0001);
		bus(CTSF_OFF_CONTROL, 1'b1, 32'h0010_0000);
		bus(CTSF_OFF_CONTROL, 1'b0, 32'h0010_0000);
		chk("capture", 32'h0000_0001, {31'h0000_0000, cap});
		for (int j = 0; j < 4; j++) begin
			q = ps[j] < 2 ? 1 : ps[j];
			bus(CTSF_OFF_TIMER, 1'b1, {16'hFFFF, 16'(ps[j])});
			gap(n);
			chk("first", 32'(q + 1), 32'(n));
			chk("prescale", 32'(ps[j]), {16'h0000, pre});
			chk("wrap", 32'h0000_0000, {16'h0000, cnt});
			gap(n);
			chk("period", 32'(q), 32'(n));
		end
		$display("test stamp done");
		repeat (2) @(posedge hclk);
		test_done();
	end
endmodule : ctsf_top_bench
`default_nettype wire
